// ==== core/async_serial_multiproc_port.sv ====
// Asynchronous serial transmitter and receiver with idle-line and address-bit
// multiprocessor block addressing.
// Assumes register port strobes and the receive pin are synchronous to clock_in.
`default_nettype none

module async_serial_multiproc_port
  import async_serial_pkg::*;
(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [15:0] reg_rdata_out,
  input wire logic serial_rx_pin_in,
  output logic serial_tx_pin_out,
  output logic tx_interrupt_out,
  output logic rx_interrupt_out
);

  // ------------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------------
  function automatic logic [7:0] len_mask(input logic [2:0] len);
    len_mask = 8'hFF >> (3'h7 - len);
  endfunction

  function automatic logic [3:0] frame_len(input logic [2:0] len, input logic par,
                                           input logic addr, input logic stop2);
    frame_len = 4'h3 + {1'b0, len} + {3'h0, par} + {3'h0, addr} + {3'h0, stop2};
  endfunction

  // Parity covers the data bits and, in address-bit mode, the address bit.
  function automatic logic par_bit(input logic [7:0] d, input logic [2:0] len,
                                   input logic addr_mode, input logic addr,
                                   input logic even);
    par_bit = (^(d & len_mask(len))) ^ (addr_mode & addr) ^ ~even;
  endfunction

  function automatic logic [12:0] frame_bits(input logic [7:0] d, input logic [7:0] fmt,
                                             input logic wake_temp_flag);
    logic [12:0] bits;
    logic [3:0] pos;
    bits = 13'h1FFE;
    pos = 4'h1;
    for (int i = 0; i < 8; i++) begin
      if (3'(i) <= fmt[CHAR_LEN_MSB:0]) begin
        bits[pos] = d[i];
        pos = pos + 4'h1;
      end
    end
    if (fmt[ADDR_MODE_BIT]) begin
      bits[pos] = wake_temp_flag;
      pos = pos + 4'h1;
    end
    if (fmt[PAR_EN_BIT]) begin
      bits[pos] = par_bit(d, fmt[CHAR_LEN_MSB:0], fmt[ADDR_MODE_BIT], wake_temp_flag,
                          fmt[PAR_EVEN_BIT]);
    end
    frame_bits = bits;
  endfunction

  // ------------------------------------------------------------------
  // Registers and state
  // ------------------------------------------------------------------
  logic [7:0] format_ff;
  logic rx_enable_ff;
  logic tx_enable_ff;
  logic sleep_ff;
  logic tx_wake_ff;
  logic tx_int_en_ff;
  logic rx_break_int_enable_ff;
  logic [9:0] div_cnt_ff;
  logic sample_tick_ff;
  logic [7:0] rx_data_buffer_ff;
  logic [7:0] rx_emulation_buffer_ff;
  logic rx_ready_flag_ff;
  logic rx_wake_flag_ff;
  logic par_err_ff;
  logic overrun_ff;
  logic frame_err_ff;
  logic [15:0] rdata_ff;
  rx_state_t rx_state_ff;
  logic [2:0] rx_samp_ff;
  logic [3:0] rx_bit_idx_ff;
  logic [11:0] rx_shift_register_ff;
  logic rx_vote_a_ff;
  logic rx_vote_b_ff;
  logic [6:0] idle_cnt_ff;
  logic idle_seen_ff;
  tx_state_t tx_state_ff;
  logic [12:0] tx_shift_register_ff;
  logic [3:0] tx_bits_left_ff;
  logic [2:0] tx_samp_ff;
  logic tx_line_ff;
  logic wake_temp_flag_ff;
  logic [7:0] txq_mem [2];
  logic txq_wr_ptr_ff;
  logic txq_rd_ptr_ff;
  logic [1:0] txq_count_ff;

  // ------------------------------------------------------------------
  // Register decode
  // ------------------------------------------------------------------
  wire wr_format = reg_wr_in & (reg_addr_in == OFS_FORMAT);
  wire wr_ctl_one = reg_wr_in & (reg_addr_in == OFS_CTL_ONE);
  wire wr_ctl_two = reg_wr_in & (reg_addr_in == OFS_CTL_TWO);
  wire wr_tx_data = reg_wr_in & (reg_addr_in == OFS_TX_DATA);
  wire rd_rx_data = reg_rd_in & (reg_addr_in == OFS_RX_DATA);

  wire [2:0] char_len = format_ff[CHAR_LEN_MSB:0];
  wire addr_mode = format_ff[ADDR_MODE_BIT];
  wire par_en = format_ff[PAR_EN_BIT];
  wire par_even = format_ff[PAR_EVEN_BIT];

  // ------------------------------------------------------------------
  // Transmit buffer: two entries between the CPU and the shifter
  // ------------------------------------------------------------------
  wire txq_full = (txq_count_ff == 2'h2);
  wire txq_valid = (txq_count_ff != 2'h0);
  wire tx_ready = ~txq_full;
  wire txq_push = wr_tx_data & tx_ready;
  wire tx_load = sample_tick_ff & (tx_state_ff == TX_IDLE) & txq_valid & tx_enable_ff;
  wire tx_empty = ~txq_valid & (tx_state_ff == TX_IDLE);
  wire [7:0] txq_head = txq_mem[txq_rd_ptr_ff];

  // Idle-line wake replaces the whole frame with eleven high bit times.
  wire tx_idle_frame = tx_wake_ff & ~addr_mode;
  wire [12:0] tx_frame = tx_idle_frame ? 13'h1FFF : frame_bits(txq_head, format_ff, tx_wake_ff);
  wire [3:0] tx_frame_len = tx_idle_frame ? TX_IDLE_BITS :
                            frame_len(char_len, par_en, addr_mode, format_ff[STOP_TWO_BIT]);

  // ------------------------------------------------------------------
  // Receive decode
  // ------------------------------------------------------------------
  wire rx_pin = serial_rx_pin_in;
  wire rx_majority = (rx_vote_a_ff & rx_vote_b_ff) | (rx_vote_a_ff & rx_pin) |
                     (rx_vote_b_ff & rx_pin);
  wire [3:0] rx_last_idx = frame_len(char_len, par_en, addr_mode, 1'b0) - 4'h2;
  wire rx_decide = sample_tick_ff & (rx_state_ff == RX_BITS) & (rx_samp_ff == VOTE_THIRD);
  wire rx_done = rx_decide & (rx_bit_idx_ff == rx_last_idx);
  wire [3:0] rx_addr_pos = {1'b0, char_len} + 4'h1;
  wire [3:0] rx_par_pos = rx_addr_pos + {3'h0, addr_mode};
  wire rx_addr_bit = addr_mode & rx_shift_register_ff[rx_addr_pos];
  wire rx_par_bad = par_en & (rx_shift_register_ff[rx_par_pos] !=
                    par_bit(rx_shift_register_ff[7:0], char_len, addr_mode, rx_addr_bit,
                            par_even));
  wire [7:0] rx_data = rx_shift_register_ff[7:0] & len_mask(char_len);
  wire rx_is_addr = addr_mode ? rx_addr_bit : idle_seen_ff;
  wire rx_accept = rx_done & rx_enable_ff & (~sleep_ff | rx_is_addr);

  // ------------------------------------------------------------------
  // Read data selection
  // ------------------------------------------------------------------
  wire rx_error = par_err_ff | overrun_ff | frame_err_ff;
  wire [7:0] ctl_one_rd = {4'h0, tx_wake_ff, sleep_ff, tx_enable_ff, rx_enable_ff};
  wire [7:0] ctl_two_rd = {tx_ready, tx_empty, 4'h0, rx_break_int_enable_ff, tx_int_en_ff};
  wire [7:0] rx_status_rd = {rx_error, rx_ready_flag_ff, 1'b0, frame_err_ff, overrun_ff,
                             par_err_ff, rx_wake_flag_ff, 1'b0};
  wire [7:0] rd_byte = (reg_addr_in == OFS_FORMAT) ? format_ff :
                       (reg_addr_in == OFS_CTL_ONE) ? ctl_one_rd :
                       (reg_addr_in == OFS_CTL_TWO) ? ctl_two_rd :
                       (reg_addr_in == OFS_RX_STATUS) ? rx_status_rd :
                       (reg_addr_in == OFS_RX_EMU) ? rx_emulation_buffer_ff :
                       (reg_addr_in == OFS_RX_DATA) ? rx_data_buffer_ff : 8'h00;

  // ------------------------------------------------------------------
  // Sample clock divider
  // ------------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (reset_in || div_cnt_ff == SAMPLE_DIV_LAST) begin
      div_cnt_ff <= 10'h000;
    end else begin
      div_cnt_ff <= div_cnt_ff + 10'h001;
    end
    sample_tick_ff <= ~reset_in & (div_cnt_ff == SAMPLE_DIV_LAST);
  end

  // ------------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      format_ff <= FORMAT_RESET;
      {tx_wake_ff, sleep_ff, tx_enable_ff, rx_enable_ff} <= CTL_ONE_RESET;
      {rx_break_int_enable_ff, tx_int_en_ff} <= CTL_TWO_RESET;
      rdata_ff <= 16'h0000;
    end else begin
      if (wr_format) begin
        format_ff <= reg_wdata_in & FORMAT_WR_MASK;
      end
      if (wr_ctl_one) begin
        rx_enable_ff <= reg_wdata_in[RX_ENA_BIT];
        tx_enable_ff <= reg_wdata_in[TX_ENA_BIT];
        sleep_ff <= reg_wdata_in[SLEEP_BIT];
        tx_wake_ff <= reg_wdata_in[TX_WAKE_BIT];
      end else if (tx_load) begin
        tx_wake_ff <= 1'b0;
      end
      if (wr_ctl_two) begin
        tx_int_en_ff <= reg_wdata_in[TX_INT_ENA_BIT];
        rx_break_int_enable_ff <= reg_wdata_in[RX_BRK_INT_ENA_BIT];
      end
      if (reg_rd_in) begin
        rdata_ff <= {8'h00, rd_byte};
      end
    end
  end

  // ------------------------------------------------------------------
  // Transmit buffer storage
  // ------------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (txq_push) begin
      txq_mem[txq_wr_ptr_ff] <= reg_wdata_in;
    end
    if (reset_in) begin
      txq_wr_ptr_ff <= 1'b0;
      txq_rd_ptr_ff <= 1'b0;
      txq_count_ff <= 2'h0;
    end else begin
      txq_wr_ptr_ff <= txq_wr_ptr_ff ^ txq_push;
      txq_rd_ptr_ff <= txq_rd_ptr_ff ^ tx_load;
      txq_count_ff <= txq_count_ff + {1'b0, txq_push} - {1'b0, tx_load};
    end
  end

  // ------------------------------------------------------------------
  // Transmitter
  // ------------------------------------------------------------------
  // The enable is checked only at load, so clearing it lets the current frame finish.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      tx_state_ff <= TX_IDLE;
      tx_shift_register_ff <= 13'h1FFF;
      tx_bits_left_ff <= 4'h0;
      tx_samp_ff <= 3'h0;
      tx_line_ff <= 1'b1;
      wake_temp_flag_ff <= 1'b0;
    end else if (tx_load) begin
      tx_state_ff <= TX_SEND;
      tx_shift_register_ff <= tx_frame;
      tx_bits_left_ff <= tx_frame_len;
      tx_samp_ff <= 3'h0;
      tx_line_ff <= tx_frame[0];
      wake_temp_flag_ff <= tx_wake_ff;
    end else if (sample_tick_ff && tx_state_ff == TX_SEND) begin
      tx_samp_ff <= tx_samp_ff + 3'h1;
      if (tx_samp_ff == SAMPLE_LAST) begin
        if (tx_bits_left_ff == 4'h1) begin
          tx_state_ff <= TX_IDLE;
          tx_line_ff <= 1'b1;
        end else begin
          tx_shift_register_ff <= {1'b1, tx_shift_register_ff[12:1]};
          tx_line_ff <= tx_shift_register_ff[1];
        end
        tx_bits_left_ff <= tx_bits_left_ff - 4'h1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Receiver bit engine
  // ------------------------------------------------------------------
  // The frame is complete at the vote of its first stop bit; a second stop is not checked.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      rx_state_ff <= RX_IDLE;
      rx_samp_ff <= 3'h0;
      rx_bit_idx_ff <= 4'h0;
      rx_shift_register_ff <= 12'h000;
      rx_vote_a_ff <= 1'b1;
      rx_vote_b_ff <= 1'b1;
    end else if (sample_tick_ff) begin
      unique case (rx_state_ff)
        RX_IDLE: begin
          if (!rx_pin) begin
            rx_samp_ff <= rx_samp_ff + 3'h1;
            if (rx_samp_ff == START_LOW_LAST) begin
              rx_state_ff <= RX_START;
            end
          end else begin
            rx_samp_ff <= 3'h0;
          end
        end
        RX_START: begin
          rx_samp_ff <= rx_samp_ff + 3'h1;
          if (rx_samp_ff == SAMPLE_LAST) begin
            rx_state_ff <= RX_BITS;
            rx_bit_idx_ff <= 4'h0;
          end
        end
        RX_BITS: begin
          rx_samp_ff <= rx_samp_ff + 3'h1;
          if (rx_samp_ff == VOTE_FIRST) begin
            rx_vote_a_ff <= rx_pin;
          end
          if (rx_samp_ff == VOTE_SECOND) begin
            rx_vote_b_ff <= rx_pin;
          end
          if (rx_done) begin
            rx_state_ff <= RX_IDLE;
            rx_samp_ff <= 3'h0;
          end else if (rx_decide) begin
            rx_shift_register_ff[rx_bit_idx_ff] <= rx_majority;
          end
          if (rx_samp_ff == SAMPLE_LAST) begin
            rx_bit_idx_ff <= rx_bit_idx_ff + 4'h1;
          end
        end
        default: begin
          rx_state_ff <= RX_IDLE;
          rx_samp_ff <= 3'h0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Idle-line block start detection
  // ------------------------------------------------------------------
  // Any low sample restarts the count, so a rejected glitch also restarts the gap.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      idle_cnt_ff <= 7'h00;
      idle_seen_ff <= 1'b0;
    end else begin
      if (sample_tick_ff && rx_state_ff == RX_IDLE) begin
        if (!rx_pin) begin
          idle_cnt_ff <= 7'h00;
        end else if (idle_cnt_ff != IDLE_BLOCK_SAMPLES) begin
          idle_cnt_ff <= idle_cnt_ff + 7'h01;
        end
      end
      if (idle_cnt_ff == IDLE_BLOCK_SAMPLES) begin
        idle_seen_ff <= 1'b1;
      end else if (rx_done) begin
        idle_seen_ff <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Receive buffers and status
  // ------------------------------------------------------------------
  // A new character wins over a buffer read in the same cycle.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      rx_data_buffer_ff <= 8'h00;
      rx_emulation_buffer_ff <= 8'h00;
      rx_ready_flag_ff <= 1'b0;
      rx_wake_flag_ff <= 1'b0;
      par_err_ff <= 1'b0;
      overrun_ff <= 1'b0;
      frame_err_ff <= 1'b0;
    end else if (rx_accept) begin
      rx_data_buffer_ff <= rx_data;
      rx_emulation_buffer_ff <= rx_data;
      rx_ready_flag_ff <= 1'b1;
      rx_wake_flag_ff <= rx_is_addr;
      par_err_ff <= rx_par_bad;
      overrun_ff <= rx_ready_flag_ff & ~rd_rx_data;
      frame_err_ff <= ~rx_majority;
    end else if (rd_rx_data) begin
      rx_ready_flag_ff <= 1'b0;
      rx_wake_flag_ff <= 1'b0;
      par_err_ff <= 1'b0;
      overrun_ff <= 1'b0;
      frame_err_ff <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign reg_rdata_out = rdata_ff;
  assign serial_tx_pin_out = tx_line_ff;
  assign tx_interrupt_out = tx_int_en_ff & tx_ready;
  assign rx_interrupt_out = rx_break_int_enable_ff & rx_ready_flag_ff;

endmodule

`default_nettype wire

// ==== core/async_serial_pkg.sv ====
// Constants shared by the asynchronous serial port with multiprocessor addressing.
// Assumes one 40 MHz clock and a simple synchronous register port.
`default_nettype none

package async_serial_pkg;

  // ------------------------------------------------------------------
  // Register offsets within the port's register frame
  // ------------------------------------------------------------------
  localparam logic [3:0] OFS_FORMAT = 4'h0;
  localparam logic [3:0] OFS_CTL_ONE = 4'h1;
  localparam logic [3:0] OFS_CTL_TWO = 4'h4;
  localparam logic [3:0] OFS_RX_STATUS = 4'h5;
  localparam logic [3:0] OFS_RX_EMU = 4'h6;
  localparam logic [3:0] OFS_RX_DATA = 4'h7;
  localparam logic [3:0] OFS_TX_DATA = 4'h9;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int CHAR_LEN_MSB = 2;
  localparam int ADDR_MODE_BIT = 3;
  localparam int PAR_EN_BIT = 5;
  localparam int PAR_EVEN_BIT = 6;
  localparam int STOP_TWO_BIT = 7;
  localparam logic [7:0] FORMAT_WR_MASK = 8'hEF;
  localparam int RX_ENA_BIT = 0;
  localparam int TX_ENA_BIT = 1;
  localparam int SLEEP_BIT = 2;
  localparam int TX_WAKE_BIT = 3;
  localparam int TX_INT_ENA_BIT = 0;
  localparam int RX_BRK_INT_ENA_BIT = 1;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] FORMAT_RESET = 8'h00;
  localparam logic [3:0] CTL_ONE_RESET = 4'h0;
  localparam logic [1:0] CTL_TWO_RESET = 2'h0;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLOCK_HZ = 40_000_000;
  localparam int BAUD_RATE = 115200;
  localparam int SAMPLES_PER_BIT = 8;
  localparam int SAMPLE_DIV = CLOCK_HZ / (BAUD_RATE * SAMPLES_PER_BIT);
  localparam logic [9:0] SAMPLE_DIV_LAST = 10'(SAMPLE_DIV - 1);
  localparam logic [2:0] START_LOW_LAST = 3'h3;
  localparam logic [2:0] VOTE_FIRST = 3'h3;
  localparam logic [2:0] VOTE_SECOND = 3'h4;
  localparam logic [2:0] VOTE_THIRD = 3'h5;
  localparam logic [2:0] SAMPLE_LAST = 3'h7;
  localparam int IDLE_BLOCK_BITS = 10;
  localparam logic [6:0] IDLE_BLOCK_SAMPLES = 7'(IDLE_BLOCK_BITS * SAMPLES_PER_BIT);
  localparam logic [3:0] TX_IDLE_BITS = 4'hB;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_BITS = 2'b10
  } rx_state_t;

  typedef enum logic {
    TX_IDLE = 1'b0,
    TX_SEND = 1'b1
  } tx_state_t;

endpackage

`default_nettype wire

// ==== testbench/serial_peer_node.sv ====
// Remote node on the serial link: sends frames to the port and captures its frames.
// Assumes every frame on the link is ten bit times long, start bit in bit 0.
`default_nettype none

module serial_peer_node
  import async_serial_pkg::*;
(
  input wire logic clock_in,
  input wire logic line_in,
  output var logic line_out
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT_CLOCKS = SAMPLE_DIV * SAMPLES_PER_BIT;
  logic [9:0] got[$];
  logic busy;

  initial begin
    line_out = 1'b1;
    busy = 1'b0;
  end

  // Calls are queued on busy so two forked senders never interleave bits.
  task automatic send_frame(input logic [9:0] bits);
    while (busy) @(negedge clock_in);
    busy = 1'b1;
    for (int i = 0; i < 10; i++) begin
      @(negedge clock_in);
      line_out = bits[i];
      repeat (BIT_CLOCKS - 1) @(negedge clock_in);
    end
    busy = 1'b0;
  endtask

  // Sampling stops at mid stop bit, so a frame following after a short gap is not missed.
  initial begin
    logic [9:0] bits;
    forever begin
      @(negedge line_in);
      repeat (BIT_CLOCKS / 2) @(posedge clock_in);
      for (int i = 0; i < 10; i++) begin
        if (i > 0) repeat (BIT_CLOCKS) @(posedge clock_in);
        bits[i] = line_in;
      end
      got.push_back(bits);
    end
  end
endmodule

`default_nettype wire

// ==== testbench/serial_port_properties.sv ====
// Concurrent checks on the serial port, seeing only its top-level ports.
// Assumes it is bound to the port from the bench and that the bench drives all inputs.
`default_nettype none

module serial_port_checker
  import async_serial_pkg::*;
(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic serial_rx_pin_in,
  input wire logic serial_tx_pin_out,
  input wire logic tx_interrupt_out,
  input wire logic rx_interrupt_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------------
  // Shadow of software-owned register bits and a line run counter
  // ------------------------------------------------------------------
  localparam int BIT_CLOCKS = SAMPLE_DIV * SAMPLES_PER_BIT;
  logic [7:0] fmt_ff;
  logic [2:0] ctl1_ff;
  logic [1:0] ctl2_ff;
  logic tx_prev_ff;
  int unsigned run_ff;
  wire logic fmt_wr = reg_wr_in && reg_addr_in == OFS_FORMAT;
  wire logic ctl1_wr = reg_wr_in && reg_addr_in == OFS_CTL_ONE;
  wire logic ctl2_wr = reg_wr_in && reg_addr_in == OFS_CTL_TWO;
  wire logic rxbuf_rd = reg_rd_in && reg_addr_in == OFS_RX_DATA;

  // The shadow only follows writes, so any format, sleep or enable bit the hardware alters on its own shows up.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      fmt_ff <= FORMAT_RESET;
      ctl1_ff <= CTL_ONE_RESET[2:0];
      ctl2_ff <= CTL_TWO_RESET;
      tx_prev_ff <= 1'b1;
      run_ff <= 0;
    end else begin
      if (fmt_wr) fmt_ff <= reg_wdata_in & FORMAT_WR_MASK;
      if (ctl1_wr) ctl1_ff <= reg_wdata_in[2:0];
      if (ctl2_wr) ctl2_ff <= reg_wdata_in[1:0];
      tx_prev_ff <= serial_tx_pin_out;
      run_ff <= (serial_tx_pin_out != tx_prev_ff) ? 1 : run_ff + 1;
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  sequence s_fmt_read;
    reg_rd_in && reg_addr_in == OFS_FORMAT;
  endsequence
  sequence s_ctl1_read;
    reg_rd_in && reg_addr_in == OFS_CTL_ONE;
  endsequence
  sequence s_int_cleared;
    $past(rxbuf_rd) || $past(ctl2_wr);
  endsequence

  chk_fmt_readback: assert property (s_fmt_read |=> reg_rdata_out == {8'h00, fmt_ff})
    else $error("format register read differs from the value written");
  chk_sleep_soft_only: assert property (s_ctl1_read |=> reg_rdata_out[2:0] == ctl1_ff)
    else $error("sleep or enable bits changed without a write");
  chk_rdata_upper_zero: assert property (reg_rdata_out[15:8] == 8'h00)
    else $error("upper byte of read data is not zero");
  chk_rx_int_gate: assert property (rx_interrupt_out |-> ctl2_ff[RX_BRK_INT_ENA_BIT])
    else $error("receive interrupt raised while disabled");
  chk_tx_int_gate: assert property (tx_interrupt_out |-> ctl2_ff[TX_INT_ENA_BIT])
    else $error("transmit interrupt raised while disabled");
  chk_rx_int_clear: assert property ($fell(rx_interrupt_out) |-> s_int_cleared)
    else $error("receive interrupt dropped without a buffer read");
  chk_tx_bit_span: assert property ($rose(serial_tx_pin_out) |-> run_ff % BIT_CLOCKS == 0)
    else $error("low period on transmit line is not whole bit times");
  chk_tx_idle_reset: assert property ($fell(reset_in) |-> serial_tx_pin_out [*8])
    else $error("transmit line not idle high after reset");
endmodule

`default_nettype wire

// ==== testbench/test_async_serial_multiproc_port.sv ====
// Self-checking bench for the serial port: register accesses plus a remote node.
// Assumes the 40 MHz clock and the fixed baud divider of the package.
`default_nettype none

bind async_serial_multiproc_port serial_port_checker checker_inst (
  .clock_in(clock_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
  .reg_rdata_out(reg_rdata_out), .serial_rx_pin_in(serial_rx_pin_in),
  .serial_tx_pin_out(serial_tx_pin_out), .tx_interrupt_out(tx_interrupt_out),
  .rx_interrupt_out(rx_interrupt_out)
);

module test_async_serial_multiproc_port
  import async_serial_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [3:0] addr = 4'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [15:0] rdata;
  logic tx_line, rx_line, tx_int, rx_int;
  int miscompares = 0;
  int check_count = 0;
  int gap;
  localparam int BIT_CLOCKS = SAMPLE_DIV * SAMPLES_PER_BIT;

  async_serial_multiproc_port dut (
    .clock_in(clock), .reset_in(reset), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .serial_rx_pin_in(rx_line), .serial_tx_pin_out(tx_line),
    .tx_interrupt_out(tx_int), .rx_interrupt_out(rx_int)
  );
  serial_peer_node peer (.clock_in(clock), .line_in(tx_line), .line_out(rx_line));

  initial begin
    forever #12.5 clock = ~clock;
  end

  // ------------------------------------------------------------------
  // Access and reporting tasks
  // ------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] expected);
    check_count++;
    if (seen !== expected) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(negedge clock);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clock);
    wr = 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, input logic [15:0] expected);
    @(negedge clock);
    addr = a;
    rd = 1'b1;
    @(negedge clock);
    rd = 1'b0;
    check(rdata, expected);
  endtask

  // Watches the receive interrupt when pick_rx_int is set, else the transmit line.
  task automatic wait_for(input bit pick_rx_int, input logic level, input int limit);
    int n = 0;
    while ((pick_rx_int ? rx_int : tx_line) !== level && n < limit) begin
      @(negedge clock);
      n++;
    end
    if ((pick_rx_int ? rx_int : tx_line) !== level) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, pick_rx_int ? rx_int : tx_line,
               level);
      conclude();
    end
  endtask

  // ------------------------------------------------------------------
  // Main sequence: both directions run at once to cover full duplex
  // ------------------------------------------------------------------
  initial begin
    repeat (8) @(negedge clock);
    reset = 1'b0;
    reg_read(OFS_FORMAT, 16'h0000);
    reg_read(OFS_CTL_TWO, 16'h00C0);
    reg_read(4'h2, 16'h0000);
    reg_write(OFS_FORMAT, 8'hFF);
    reg_read(OFS_FORMAT, 16'h00EF);
    // Five data bits, address-bit mode, even parity, two stop bits.
    reg_write(OFS_FORMAT, 8'hEC);
    reg_write(OFS_CTL_TWO, 8'h03);
    reg_write(OFS_CTL_ONE, 8'h0F);
    reg_write(OFS_TX_DATA, 8'h15);
    fork
      peer.send_frame({2'b11, 1'b1, 1'b1, 5'h0A, 1'b0});
    join_none
    wait_for(1'b0, 1'b0, 1000);
    reg_read(OFS_CTL_ONE, 16'h0007);
    reg_write(OFS_TX_DATA, 8'h07);
    wait_for(1'b1, 1'b1, 50000);
    reg_read(OFS_RX_STATUS, 16'h0042);
    reg_read(OFS_RX_EMU, 16'h000A);
    reg_read(OFS_RX_DATA, 16'h000A);
    check(16'(rx_int), 16'h0000);
    // The address does not match, so sleep stays set for the rest of the block.
    reg_read(OFS_CTL_ONE, 16'h0007);
    fork
      peer.send_frame({2'b11, 1'b1, 1'b0, 5'h13, 1'b0});
    join_none
    for (int n = 0; n < 60000 && (peer.got.size() < 2 || peer.busy); n++) @(negedge clock);
    // The second stop bit of the last frame may still be on the line.
    repeat (BIT_CLOCKS) @(negedge clock);
    check(16'(peer.got.size()), 16'h0002);
    reg_read(OFS_RX_STATUS, 16'h0000);
    check(16'(rx_int), 16'h0000);
    check(16'(peer.got[0]), 16'({2'b11, 1'b0, 1'b1, 5'h15, 1'b0}));
    check(16'(peer.got[1]), 16'({2'b11, 1'b1, 1'b0, 5'h07, 1'b0}));
    reg_read(OFS_CTL_TWO, 16'h00C3);
    check(16'(tx_int), 16'h0001);
    // Idle-line mode, eight data bits, no parity, one stop bit: ten-bit frames.
    reg_write(OFS_FORMAT, 8'h07);
    reg_write(OFS_CTL_ONE, 8'h0F);
    reg_write(OFS_TX_DATA, 8'hA5);
    reg_write(OFS_TX_DATA, 8'h3C);
    fork
      begin
        repeat (10 * BIT_CLOCKS) @(negedge clock);
        peer.send_frame({1'b1, 8'h5A, 1'b0});
      end
    join_none
    gap = 0;
    while (tx_line && gap < 20 * BIT_CLOCKS) begin
      @(negedge clock);
      gap++;
    end
    check(16'(gap / BIT_CLOCKS), 16'h000B);
    reg_read(OFS_CTL_ONE, 16'h0007);
    wait_for(1'b1, 1'b1, 12 * BIT_CLOCKS);
    reg_read(OFS_RX_STATUS, 16'h0042);
    reg_read(OFS_RX_DATA, 16'h005A);
    for (int n = 0; n < 12 * BIT_CLOCKS && peer.got.size() < 3; n++) @(negedge clock);
    check(16'(peer.got.size()), 16'h0003);
    check(16'(peer.got[2]), 16'({1'b1, 8'h3C, 1'b0}));
    conclude();
  end
endmodule

`default_nettype wire
